//--- design/rsc_reset_source.v
// reset source control: selectors, brownout filter, cause flags
// Operation
// - selector 55h routes pin to general use, AAh enables external reset pin
// - other selector value resets device after soft delay and sets fault flag
// - selector returns to 55h on every reset except sleep watchdog warm reset
// - external reset function overrides other shared functions on that pin
// - flag register bits 7 to 4 read zero
// - selector fault flag bit 3 set by hardware, cleared by software zero
// - enabled brownout low longer than filter time resets, sets flag
// - low supply no longer than filter time is ignored
// - brownout selector decodes five thresholds and F0h disable
// - undefined brownout selector resets after delay, restores 66h
// - genuine brownout reset leaves brownout selector unchanged
// - brownout detection off in idle or sleep
// - brownout flag bit 2 set on brownout reset, software clears
// - brownout setting fault flag bit 1 set on undefined pattern
// - writing 55h to second flash control resets whole device
// - active-mode watchdog expiry resets device, sets expiry flag
// - low-power watchdog expiry clears only pc and stack, sets flag
// - watchdog setting fault flag bit 0 set on bad watchdog pattern
// - low-power watchdog expiry leaves expiry and powerdown flags set
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "rsc_consts.vh"

module rsc_reset_source #(
   parameter SRST_CYC = (`RSC_SRST_NS * `RSC_CLK_MHZ + 999) / 1000,
   parameter BOF_CYC = (`RSC_BOF_NS * `RSC_CLK_MHZ + 999) / 1000
) (
   // clock and power-on reset
   input wire clk_sys,
   input wire reset,
   // register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // pin and analogue inputs (asynchronous)
   input wire external_clear_pin_n,
   input wire supply_low,
   // core state and events (same clock)
   input wire lowpower_mode,
   input wire watchdog_expire,
   input wire watchdog_bad_pattern,
   // pin function
   output wire shared_pin_gpio_en,
   output wire external_clear_en,
   // brownout threshold select, one-hot, zero when disabled
   output reg [4:0] brownout_threshold_sel,
   // reset outputs
   output reg core_reset,
   output reg pc_stack_clear,
   output reg watchdog_expiry_flag,
   output reg powerdown_flag
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg [1:0] pin_sync_r;
reg [1:0] low_sync_r;
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      pin_sync_r <= 2'h3;
      low_sync_r <= 2'h0;
   end else begin
      pin_sync_r <= {pin_sync_r[0], external_clear_pin_n};
      low_sync_r <= {low_sync_r[0], supply_low};
   end
end

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] pinsel_r;
reg [7:0] bolvl_r;
reg [3:0] flags_r;
reg [15:0] srst_cnt_r;
reg [15:0] bof_cnt_r;
reg [3:0] hold_r;
reg pin_bad_r;
reg bo_bad_r;
reg bo_evt_r;

wire wr_pin = reg_wr && (reg_addr == `RSC_ADDR_PINSEL);
wire wr_flg = reg_wr && (reg_addr == `RSC_ADDR_FLAGS);
wire wr_bo = reg_wr && (reg_addr == `RSC_ADDR_BOLVL);
wire flash_rst = reg_wr && (reg_addr == `RSC_ADDR_FLASH2) &&
   (reg_wdata == `RSC_FLASH_RST);

wire pin_gpio = (pinsel_r == `RSC_PIN_GPIO);
wire pin_ext = (pinsel_r == `RSC_PIN_EXT);
assign external_clear_en = pin_ext;
assign shared_pin_gpio_en = !pin_ext;

reg bo_ok;
always @* begin
   bo_ok = 1'b1;
   case (bolvl_r)
      `RSC_BO_L0: brownout_threshold_sel = 5'h01;
      `RSC_BO_L1: brownout_threshold_sel = 5'h02;
      `RSC_BO_L2: brownout_threshold_sel = 5'h04;
      `RSC_BO_L3: brownout_threshold_sel = 5'h08;
      `RSC_BO_L4: brownout_threshold_sel = 5'h10;
      `RSC_BO_OFF: brownout_threshold_sel = 5'h00;
      default: begin
         brownout_threshold_sel = 5'h00;
         bo_ok = 1'b0;
      end
   endcase
end

// detection gated off in low power
wire bo_active = (brownout_threshold_sel != 5'h00) && !lowpower_mode;
wire pin_fault = !pin_gpio && !pin_ext;
wire ext_clear = pin_ext && !pin_sync_r[1];
wire srst_done = (srst_cnt_r == SRST_CYC[15:0]);
wire bo_fire = bo_active && low_sync_r[1] && (bof_cnt_r == BOF_CYC[15:0]);
wire wd_warm = watchdog_expire && lowpower_mode;
wire wd_cold = watchdog_expire && !lowpower_mode;
wire cold_req = srst_done || bo_fire || flash_rst || wd_cold ||
   watchdog_bad_pattern || ext_clear;

// ----------------------------------------
// brownout filter
// ----------------------------------------
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      bof_cnt_r <= 16'h0000;
   // short low pulses restart the count
   end else if (!bo_active || !low_sync_r[1] || core_reset) begin
      bof_cnt_r <= 16'h0000;
   end else if (bof_cnt_r != BOF_CYC[15:0]) begin
      bof_cnt_r <= bof_cnt_r + 16'h0001;
   end
end

// ----------------------------------------
// soft reset delay
// ----------------------------------------
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      srst_cnt_r <= 16'h0000;
   // counts while any protected pattern is bad
   end else if (!(pin_fault || !bo_ok) || core_reset) begin
      srst_cnt_r <= 16'h0000;
   end else if (!srst_done) begin
      srst_cnt_r <= srst_cnt_r + 16'h0001;
   end
end

// ----------------------------------------
// protected selectors and flags
// ----------------------------------------
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      pinsel_r <= `RSC_PIN_GPIO;
      bolvl_r <= `RSC_BO_L0;
      flags_r <= 4'h0;
      pin_bad_r <= 1'b0;
      bo_bad_r <= 1'b0;
      bo_evt_r <= 1'b0;
   end else begin
      // latch which source fires, for the release cycle
      if (cold_req) begin
         pin_bad_r <= srst_done && pin_fault;
         bo_bad_r <= srst_done && !bo_ok;
         bo_evt_r <= bo_fire;
      end
      if (hold_r == 4'h1) begin
         // cold resets restore the pin selector
         pinsel_r <= `RSC_PIN_GPIO;
         if (bo_bad_r) begin
            bolvl_r <= `RSC_BO_L0;
         end
      end else if (!core_reset) begin
         if (wr_pin) begin
            pinsel_r <= reg_wdata;
         end
         if (wr_bo) begin
            bolvl_r <= reg_wdata;
         end
      end
      // selector fault flagged on its reset
      // software may only clear; set wins
      flags_r <= (wr_flg ? (flags_r & reg_wdata[3:0]) : flags_r) |
         {(hold_r == 4'h1) && pin_bad_r,
          (hold_r == 4'h1) && bo_evt_r,
          (hold_r == 4'h1) && bo_bad_r,
          watchdog_bad_pattern};
   end
end

// ----------------------------------------
// reset generation and core status
// ----------------------------------------
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      hold_r <= 4'h0;
      core_reset <= 1'b1;
      pc_stack_clear <= 1'b0;
      watchdog_expiry_flag <= 1'b0;
      powerdown_flag <= 1'b0;
   end else begin
      // device reset held a few cycles
      if (cold_req) begin
         hold_r <= `RSC_RST_HOLD;
      end else if (hold_r != 4'h0) begin
         hold_r <= hold_r - 4'h1;
      end
      core_reset <= cold_req || (hold_r > 4'h1);
      // warm reset clears only pc and stack
      pc_stack_clear <= wd_warm || cold_req;
      if (watchdog_expire) begin
         watchdog_expiry_flag <= 1'b1;
      end
      if (wd_warm) begin
         powerdown_flag <= 1'b1;
      end
   end
end

// ----------------------------------------
// register read
// ----------------------------------------
always @(posedge clk_sys or posedge reset) begin
   if (reset) begin
      reg_rdata <= 8'h00;
   end else if (reg_rd) begin
      case (reg_addr)
         `RSC_ADDR_PINSEL: reg_rdata <= pinsel_r;
         `RSC_ADDR_FLAGS: reg_rdata <= {4'h0, flags_r};
         `RSC_ADDR_BOLVL: reg_rdata <= bolvl_r;
         `RSC_ADDR_STATUS: reg_rdata <= {6'h00, powerdown_flag,
            watchdog_expiry_flag};
         default: reg_rdata <= 8'h00;
      endcase
   end else begin
      reg_rdata <= 8'h00;
   end
end

endmodule

//--- design/rsc_consts.vh
// constants for the reset source control block
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define RSC_ADDR_PINSEL 4'h0
`define RSC_ADDR_FLAGS 4'h1
`define RSC_ADDR_BOLVL 4'h2
`define RSC_ADDR_FLASH2 4'h3
`define RSC_ADDR_STATUS 4'h4

// ----------------------------------------
// patterns and reset values
// ----------------------------------------
`define RSC_PIN_GPIO 8'h55
`define RSC_PIN_EXT 8'hAA
`define RSC_BO_L0 8'h66
`define RSC_BO_L1 8'h55
`define RSC_BO_L2 8'h33
`define RSC_BO_L3 8'h99
`define RSC_BO_L4 8'hAA
`define RSC_BO_OFF 8'hF0
`define RSC_FLASH_RST 8'h55

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define RSC_F_SEL 3
`define RSC_F_BO 2
`define RSC_F_BOSET 1
`define RSC_F_WDSET 0

// ----------------------------------------
// timing
// ----------------------------------------
`define RSC_CLK_MHZ 125
`define RSC_SRST_NS 1000
`define RSC_BOF_NS 120
`define RSC_RST_HOLD 4'h4

`endif

//--- sim/rsc_core_model.sv
// core model: turns bench requests into watchdog and mode signals
`timescale 1ns/1ns
module rsc_core_model (
   // clock and device reset
   input wire clk_sys,
   input wire core_reset,
   // bench requests
   input wire go_wd,
   input wire go_bad,
   input wire slp,
   // to the block
   output logic lowpower_mode,
   output logic watchdog_expire,
   output logic watchdog_bad_pattern
);
   always @(posedge clk_sys) begin
      watchdog_expire <= go_wd;
      watchdog_bad_pattern <= go_bad;
      lowpower_mode <= slp & ~core_reset;
   end
endmodule

//--- sim/rsc_reset_source_checker.sv
// assertions on the reset source block ports
`timescale 1ns/1ns
module rsc_reset_source_checker #(
   parameter SRST_CYC = 4,
   parameter BOF_CYC = 4
) (
   // clock, reset, bus
   input wire clk_sys,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // core side
   input wire lowpower_mode,
   input wire watchdog_expire,
   // outputs
   input wire shared_pin_gpio_en,
   input wire external_clear_en,
   input wire [4:0] brownout_threshold_sel,
   input wire core_reset,
   input wire pc_stack_clear,
   input wire watchdog_expiry_flag,
   input wire powerdown_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   pin_route_a: assert property (
      external_clear_en != shared_pin_gpio_en) else $error("pin route");
   thr_onehot_a: assert property (
      $onehot0(brownout_threshold_sel)) else $error("threshold select");
   flash_rst_a: assert property (
      reg_wr && reg_addr == 4'h3 && reg_wdata == 8'h55 && !core_reset
      |=> core_reset) else $error("flash reset");
   flag_hi_a: assert property (
      reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:4] == 4'h0)
      else $error("flag high bits");
   wd_active_a: assert property (
      watchdog_expire && !lowpower_mode |-> ##[1:3] core_reset)
      else $error("active expiry");
   wd_sleep_a: assert property (
      watchdog_expire && lowpower_mode |-> ##[1:2] pc_stack_clear)
      else $error("sleep expiry");
   wd_flags_a: assert property (
      watchdog_expire && lowpower_mode
      |-> ##[1:3] watchdog_expiry_flag && powerdown_flag)
      else $error("sleep flags");
   sleep_warm_a: assert property (
      watchdog_expire && lowpower_mode && !core_reset
      |=> !core_reset [*3]) else $error("sleep reset");
endmodule
bind rsc_reset_source rsc_reset_source_checker #(.SRST_CYC(SRST_CYC),
   .BOF_CYC(BOF_CYC)) chk_i (.clk_sys(clk_sys), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lowpower_mode(lowpower_mode),
   .watchdog_expire(watchdog_expire),
   .shared_pin_gpio_en(shared_pin_gpio_en),
   .external_clear_en(external_clear_en),
   .brownout_threshold_sel(brownout_threshold_sel),
   .core_reset(core_reset), .pc_stack_clear(pc_stack_clear),
   .watchdog_expiry_flag(watchdog_expiry_flag),
   .powerdown_flag(powerdown_flag));

//--- sim/rsc_reset_source_tb.sv
// testbench for the reset source block
`timescale 1ns/1ns
module rsc_reset_source_tb;
   logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, pin_n = 1, sup = 0;
   logic go_wd = 0, go_bad = 0, slp = 0;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0;
   logic [7:0] pat [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
   wire [7:0] reg_rdata;
   wire [4:0] thr;
   wire gpio_en, ext_en, core_reset, pcc, to_f, pd_f, lpm, wde, wdb;
   int bad_count = 0, cmp_count = 0;
   rsc_reset_source #(.SRST_CYC(4), .BOF_CYC(4)) uut (.clk_sys(clk_sys),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_clear_pin_n(pin_n), .supply_low(sup), .lowpower_mode(lpm),
      .watchdog_expire(wde), .watchdog_bad_pattern(wdb),
      .shared_pin_gpio_en(gpio_en), .external_clear_en(ext_en),
      .brownout_threshold_sel(thr), .core_reset(core_reset),
      .pc_stack_clear(pcc), .watchdog_expiry_flag(to_f),
      .powerdown_flag(pd_f));
   rsc_core_model core (.clk_sys(clk_sys), .core_reset(core_reset),
      .go_wd(go_wd), .go_bad(go_bad), .slp(slp), .lowpower_mode(lpm),
      .watchdog_expire(wde), .watchdog_bad_pattern(wdb));
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge clk_sys);
      reg_wr <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1;
      chk($sformatf("reg%0h", a), reg_rdata, e);
   endtask
   task wlev(input logic v);
      int n;
      n = 0;
      while (core_reset !== v && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("core_reset", {7'h0, core_reset}, {7'h0, v});
   endtask
   // one-cycle pulse: 0 supply low, 1 bad watchdog pattern, 2 expiry
   task pulse(input int k);
      @(posedge clk_sys);
      case (k)
         0: sup <= 1;
         1: go_bad <= 1;
         default: go_wd <= 1;
      endcase
      @(posedge clk_sys);
      case (k)
         0: sup <= 0;
         1: go_bad <= 0;
         default: go_wd <= 0;
      endcase
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      test_done;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= 0;
      @(posedge clk_sys);
      rd(0, 8'h55);
      rd(2, 8'h66);
      rd(1, 8'h00);
      rd(5, 8'h00);
      $display("defaults done");
      wr(0, 8'hAA);
      #1 chk("gpio_en", {7'h0, gpio_en}, 8'h00);
      pin_n <= 0;
      wlev(1);
      pin_n <= 1;
      wlev(0);
      rd(0, 8'h55);
      $display("pin done");
      for (int i = 0; i < 6; i++) begin
         wr(2, pat[i]);
         #1 chk("thr", {3'h0, thr}, (i < 5) ? 8'h01 << i : 8'h00);
      end
      wr(2, 8'h33);
      pulse(0);
      repeat (8) @(posedge clk_sys);
      chk("short low", {7'h0, core_reset}, 8'h00);
      sup <= 1;
      wlev(1);
      sup <= 0;
      wlev(0);
      rd(2, 8'h33);
      rd(1, 8'h04);
      wr(1, 8'h00);
      wr(2, 8'h12);
      wlev(1);
      wlev(0);
      rd(2, 8'h66);
      rd(1, 8'h02);
      wr(0, 8'h00);
      wlev(1);
      wlev(0);
      rd(0, 8'h55);
      rd(1, 8'h0A);
      wr(1, 8'hFF);
      rd(1, 8'h0A);
      wr(1, 8'h00);
      rd(1, 8'h00);
      pulse(1);
      rd(1, 8'h01);
      wlev(0);
      $display("flags done");
      wr(0, 8'hAA);
      slp <= 1;
      repeat (3) @(posedge clk_sys);
      pulse(2);
      repeat (3) @(posedge clk_sys);
      chk("to_pd", {6'h0, to_f, pd_f}, 8'h03);
      rd(0, 8'hAA);
      rd(4, 8'h03);
      slp <= 0;
      repeat (2) @(posedge clk_sys);
      pulse(2);
      wlev(1);
      wlev(0);
      wr(3, 8'h55);
      wlev(1);
      wlev(0);
      $display("resets done");
      test_done;
   end
endmodule
